//--- design/rgb_drive_map.svh
// Register offsets, field positions, reset values and table layout
`ifndef RGB_DRIVE_MAP_SVH
`define RGB_DRIVE_MAP_SVH
`define CTRL_OFS        8'h00
`define CUR_R_OFS       8'h01
`define CUR_G_OFS       8'h02
`define CUR_B_OFS       8'h03
`define BRIGHT_OFS      8'h05
`define GAIN_R_OFS      8'h0A
`define GAIN_G_OFS      8'h0B
`define GAIN_B_OFS      8'h0C
`define ADC_LO_OFS      8'h0D
`define ADC_HI_OFS      8'h0E
`define COMP_SEL_BIT    0
`define BRC_OFF_BIT     1
`define AUTO_BIT        3
`define SEQ_LO_BIT      6
`define SEQ_HI_BIT      7
`define CTRL_RST        8'h00
`define CUR_RST         8'h00
`define BRIGHT_RST      8'h07
`define GAIN_RST        8'h80
`define GAIN_SHIFT      7
`define NVM_PTS         6'd11
`define NVM_CUR_BASE    6'd33
`define NVM_CAL         6'd36
`define NVM_HEAT        6'd37
`define NVM_WORDS       38
`define LAST_IDX        4'hA
`define FRAC_BITS       4
`define PWM_BITS        12
`define PWM_MAX         12'hFFF
`define LEVEL_MAX       3'h7
`define FADE_STEP_CYC   4096
`endif

//--- design/rgb_drive_pkg.sv
// Types for the RGB mode and compensation block
package rgb_drive_pkg;
	typedef enum logic [1:0] {
		MODE_MANUAL   = 2'b00,
		MODE_AUTO_OVL = 2'b01,
		MODE_AUTO_SEQ = 2'b10
	} op_mode_e;
	typedef enum logic {
		SEQ_IDLE = 1'b0,
		SEQ_RUN  = 1'b1
	} seq_state_e;
	typedef struct packed {
		logic [7:0]        ctrl;
		logic [2:0][7:0]   cur_ctl;
		logic [7:0]        bright;
		logic [2:0][7:0]   gain;
		logic [11:0]       adc_res;
		logic [7:0]        rdata;
		op_mode_e          mode;
		seq_state_e        seq;
		logic [1:0]        seq_col;
		logic [2:0]        seq_left;
		logic [11:0]       cnt;
		logic [2:0][11:0]  duty;
		logic [2:0]        level;
		logic [15:0]       fade_cnt;
		logic [2:0]        gate_prev;
		logic [2:0]        led_on;
		logic [2:0][7:0]   led_cur;
	} state_s;
endpackage

//--- design/rgb_drive.sv
// RGB drive mode control, temperature compensation and PWM generation
//
// Contract
// - Auto flag is control bit 3; sequence count is control bits 6-7.
// - Flag 0 manual; flag 1 with 00 overlap; nonzero field sequential; control bit 1 clear (stand-alone) forces overlap.
// - Manual mode: no internal PWM, DC current from current registers.
// - Manual mode: each output gated by its own external gate input.
// - Manual mode: no brightness, compensation, fading or sequencing.
// - Auto mode: 12-bit duty from table chosen by sensor reading.
// - Table points every 16 degrees; values between are interpolated.
// - Two sensor inputs; reading mapped to table address via calibration.
// - Select bit picks compensation input; its result is readable.
// - Auto mode current codes are 8-bit, loaded from table memory.
// - Brightness register 05H holds 3-bit log code for all colours.
// - Fading ramps brightness changes keeping colour proportions.
// - Gain registers 0AH-0CH scale each colour's duty from 0 to 2.
// - Reading corrected by self-heating offset scaled by red duty.
// - Sequential mode: gate pulses trigger a new sequence.
// - Stand-alone: brightness only from the pseudo-PWM level input.
`timescale 1ns/1ps
`include "rgb_drive_map.svh"
module rgb_drive
	import rgb_drive_pkg::*;
#(
	parameter int FADE_STEP_CYCLES = `FADE_STEP_CYC
) (
	input  wire logic        clock,
	input  wire logic        reset,
	input  wire logic [7:0]  reg_addr,
	input  wire logic [7:0]  reg_wdata,
	input  wire logic        reg_write,
	input  wire logic        reg_read,
	output logic      [7:0]  reg_rdata,
	input  wire logic        ext_gate_red,
	input  wire logic        ext_gate_green,
	input  wire logic        ext_gate_blue,
	input  wire logic [11:0] sensor_input_one,
	input  wire logic [11:0] sensor_input_two,
	input  wire logic [2:0]  pseudo_pwm_level_input,
	input  wire logic        nvm_write,
	input  wire logic [5:0]  nvm_index,
	input  wire logic [11:0] nvm_data,
	output logic             led_on_red,
	output logic             led_on_green,
	output logic             led_on_blue,
	output logic      [7:0]  led_current_red,
	output logic      [7:0]  led_current_green,
	output logic      [7:0]  led_current_blue
);
	localparam logic [15:0] FADE_LAST = 16'(FADE_STEP_CYCLES - 1);

	state_s      st_reg;
	state_s      st_next;
	logic [11:0] nvm_mem [`NVM_WORDS];
	logic [2:0]  gates;

	assign gates = {ext_gate_blue, ext_gate_green, ext_gate_red};

	function automatic op_mode_e decode_mode(input logic [7:0] c);
		if (!c[`AUTO_BIT])
			return MODE_MANUAL;
		else if (c[`SEQ_HI_BIT:`SEQ_LO_BIT] == 2'b00)
			return MODE_AUTO_OVL;
		else
			return MODE_AUTO_SEQ;
	endfunction

	function automatic logic [11:0] interp(input logic [11:0] a,
		input logic [11:0] b, input logic [3:0] f);
		logic signed [17:0] d;
		logic signed [17:0] sum;
		d = $signed({6'h00, b}) - $signed({6'h00, a});
		d = d * $signed({14'h0000, f});
		sum = $signed({6'h00, a}) + (d >>> `FRAC_BITS);
		return sum[11:0];
	endfunction

	function automatic logic [11:0] apply_gain(input logic [11:0] v,
		input logic [7:0] g);
		logic [19:0] p;
		p = {8'h00, v} * {12'h000, g};
		p = p >> `GAIN_SHIFT;
		return (p[19:12] != 8'h00) ? `PWM_MAX : p[11:0];
	endfunction

	// Table programming port
	always_ff @(posedge clock) begin
		if (nvm_write && (nvm_index < 6'(`NVM_WORDS)))
			nvm_mem[nvm_index] <= nvm_data;
	end

	always_comb begin
		logic        standalone;
		logic [11:0] adc_sel;
		logic [12:0] cal;
		logic [23:0] heat;
		logic [12:0] corr;
		logic [3:0]  i0;
		logic [3:0]  i1;
		logic [3:0]  frac;
		logic [2:0]  target;
		logic [11:0] tval;
		logic [2:0]  seq_len;
		logic        trig;
		logic        wrap;
		op_mode_e    md;
		standalone = 1'b0;
		adc_sel = 12'h000;
		cal = 13'h0000;
		heat = 24'h000000;
		corr = 13'h0000;
		i0 = 4'h0;
		i1 = 4'h0;
		frac = 4'h0;
		target = 3'h0;
		tval = 12'h000;
		seq_len = 3'h0;
		trig = 1'b0;
		wrap = 1'b0;
		md = MODE_MANUAL;
		st_next = st_reg;

		// Register writes
		if (reg_write) begin
			case (reg_addr)
			`CTRL_OFS:   st_next.ctrl = reg_wdata;
			`CUR_R_OFS:  st_next.cur_ctl[0] = reg_wdata;
			`CUR_G_OFS:  st_next.cur_ctl[1] = reg_wdata;
			`CUR_B_OFS:  st_next.cur_ctl[2] = reg_wdata;
			`BRIGHT_OFS: st_next.bright = {5'h00, reg_wdata[2:0]};
			`GAIN_R_OFS: st_next.gain[0] = reg_wdata;
			`GAIN_G_OFS: st_next.gain[1] = reg_wdata;
			`GAIN_B_OFS: st_next.gain[2] = reg_wdata;
			default:     st_next.ctrl = st_reg.ctrl;
			endcase
		end

		// Register reads
		if (reg_read) begin
			case (reg_addr)
			`CTRL_OFS:   st_next.rdata = st_reg.ctrl;
			`CUR_R_OFS:  st_next.rdata = st_reg.cur_ctl[0];
			`CUR_G_OFS:  st_next.rdata = st_reg.cur_ctl[1];
			`CUR_B_OFS:  st_next.rdata = st_reg.cur_ctl[2];
			`BRIGHT_OFS: st_next.rdata = st_reg.bright;
			`GAIN_R_OFS: st_next.rdata = st_reg.gain[0];
			`GAIN_G_OFS: st_next.rdata = st_reg.gain[1];
			`GAIN_B_OFS: st_next.rdata = st_reg.gain[2];
			`ADC_LO_OFS: st_next.rdata = st_reg.adc_res[7:0];
			`ADC_HI_OFS: st_next.rdata = {4'h0, st_reg.adc_res[11:8]};
			default:     st_next.rdata = 8'h00;
			endcase
		end

		// Mode decode; stand-alone forces overlapping automatic drive
		standalone = !st_reg.ctrl[`BRC_OFF_BIT];
		md = standalone ? MODE_AUTO_OVL : decode_mode(st_reg.ctrl);
		st_next.mode = md;

		// Compensation input select and readback
		adc_sel = st_reg.ctrl[`COMP_SEL_BIT] ? sensor_input_two
			: sensor_input_one;
		st_next.adc_res = adc_sel;

		// Calibrated reading, less self-heating scaled by red duty
		cal = {1'b0, adc_sel} - {1'b0, nvm_mem[`NVM_CAL]};
		if (cal[12])
			cal = 13'h0000;
		heat = {12'h000, nvm_mem[`NVM_HEAT]} * {12'h000, st_reg.duty[0]};
		corr = cal - {1'b0, heat[23:12]};
		if (corr[12])
			corr = 13'h0000;

		// Table address and interpolation fraction
		if (corr[11:4] >= {4'h0, `LAST_IDX}) begin
			i0 = `LAST_IDX;
			i1 = `LAST_IDX;
			frac = 4'h0;
		end else begin
			i0 = corr[7:4];
			i1 = corr[7:4] + 4'h1;
			frac = corr[3:0];
		end

		// Fade the applied level one step at a time; manual mode takes the target at once
		target = standalone ? pseudo_pwm_level_input
			: st_reg.bright[2:0];
		st_next.fade_cnt = (st_reg.fade_cnt == FADE_LAST) ? 16'h0000
			: st_reg.fade_cnt + 16'h0001;
		if (md == MODE_MANUAL) begin
			st_next.level = target;
		end else if (st_reg.fade_cnt == FADE_LAST) begin
			if (st_reg.level < target)
				st_next.level = st_reg.level + 3'h1;
			else if (st_reg.level > target)
				st_next.level = st_reg.level - 3'h1;
		end

		// PWM period counter; duties latch at period end, held at zero in manual mode
		st_next.cnt = st_reg.cnt + 12'h001;
		wrap = (st_reg.cnt == `PWM_MAX);
		for (int c = 0; c < 3; c++) begin
			tval = interp(nvm_mem[6'(c) * `NVM_PTS + {2'b00, i0}],
				nvm_mem[6'(c) * `NVM_PTS + {2'b00, i1}], frac);
			tval = apply_gain(tval, st_reg.gain[c]);
			tval = tval >> (`LEVEL_MAX - st_reg.level);
			if (md == MODE_MANUAL)
				st_next.duty[c] = 12'h000;
			else if (wrap)
				st_next.duty[c] = tval;
		end

		// Sequencer, started by any gate rising edge
		seq_len = {1'b0, st_reg.ctrl[`SEQ_HI_BIT:`SEQ_LO_BIT]} + 3'h1;
		trig = |(gates & ~st_reg.gate_prev);
		st_next.gate_prev = gates;
		if (md != MODE_AUTO_SEQ) begin
			st_next.seq = SEQ_IDLE;
			st_next.seq_left = 3'h0;
			st_next.seq_col = 2'h0;
		end else if (trig) begin
			st_next.seq = SEQ_RUN;
			st_next.seq_left = seq_len;
			st_next.seq_col = 2'h0;
		end else if (wrap && st_reg.seq == SEQ_RUN) begin
			st_next.seq_col = (st_reg.seq_col == 2'h2) ? 2'h0
				: st_reg.seq_col + 2'h1;
			st_next.seq_left = st_reg.seq_left - 3'h1;
			if (st_reg.seq_left == 3'h1)
				st_next.seq = SEQ_IDLE;
		end

		// Output drive per mode
		for (int c = 0; c < 3; c++) begin
			case (md)
			MODE_MANUAL: begin
				st_next.led_on[c] = gates[c];
				st_next.led_cur[c] = st_reg.cur_ctl[c];
			end
			MODE_AUTO_OVL: begin
				st_next.led_on[c] = st_reg.cnt < st_reg.duty[c];
				st_next.led_cur[c] = nvm_mem[`NVM_CUR_BASE + 6'(c)][7:0];
			end
			MODE_AUTO_SEQ: begin
				st_next.led_on[c] = (st_reg.seq == SEQ_RUN)
					&& (st_reg.seq_col == 2'(c))
					&& (st_reg.cnt < st_reg.duty[c]);
				st_next.led_cur[c] = nvm_mem[`NVM_CUR_BASE + 6'(c)][7:0];
			end
			default: begin
				st_next.led_on[c] = 1'b0;
				st_next.led_cur[c] = 8'h00;
			end
			endcase
		end
	end

	always_ff @(posedge clock) begin
		if (reset) begin
			st_reg <= '0;
			st_reg.ctrl <= `CTRL_RST;
			st_reg.cur_ctl <= {3{`CUR_RST}};
			st_reg.bright <= `BRIGHT_RST;
			st_reg.gain <= {3{`GAIN_RST}};
			st_reg.mode <= MODE_AUTO_OVL; // Cleared control is stand-alone
			st_reg.seq <= SEQ_IDLE;
		end else begin
			st_reg <= st_next;
		end
	end

	assign reg_rdata = st_reg.rdata;
	assign led_on_red = st_reg.led_on[0];
	assign led_on_green = st_reg.led_on[1];
	assign led_on_blue = st_reg.led_on[2];
	assign led_current_red = st_reg.led_cur[0];
	assign led_current_green = st_reg.led_cur[1];
	assign led_current_blue = st_reg.led_cur[2];

	default clocking cb @(posedge clock);
	endclocking
	default disable iff (reset);

	sequence seq_ctrl_written;
		reg_write && reg_addr == `CTRL_OFS && reg_wdata == 8'h4A;
	endsequence
	sequence seq_started;
		st_reg.seq == SEQ_IDLE ##1 st_reg.seq == SEQ_RUN;
	endsequence

	chk_ctrl_write: assert property (
		reg_write && reg_addr == `CTRL_OFS |=> st_reg.ctrl == $past(reg_wdata))
		else $error("control register did not take write");
	chk_mode_sequential: assert property (
		seq_ctrl_written |-> ##2 st_reg.mode == MODE_AUTO_SEQ)
		else $error("sequential mode not decoded");
	chk_manual_current: assert property (
		st_reg.mode == MODE_MANUAL |-> st_reg.led_cur == $past(st_reg.cur_ctl))
		else $error("manual current not from current registers");
	chk_manual_gate: assert property (
		st_reg.mode == MODE_MANUAL |-> st_reg.led_on == $past(gates))
		else $error("manual output not following gate");
	chk_manual_quiet: assert property (
		st_reg.mode == MODE_MANUAL |-> st_reg.seq == SEQ_IDLE)
		else $error("sequencer running in manual mode");
	chk_adc_readback: assert property (
		reg_read && reg_addr == `ADC_LO_OFS
		|=> st_reg.rdata == $past(st_reg.adc_res[7:0]))
		else $error("sensor readback mismatch");
	chk_fade_step: assert property (
		$changed(st_reg.level) && st_reg.mode != MODE_MANUAL
		|-> st_reg.level == $past(st_reg.level) + 3'h1
		|| st_reg.level == $past(st_reg.level) - 3'h1)
		else $error("fade jumped more than one step");
	chk_seq_length: assert property (
		seq_started |-> st_reg.seq_left >= 3'h2 && st_reg.seq_left <= 3'h4)
		else $error("sequence length out of range");
	chk_seq_single: assert property (
		st_reg.mode == MODE_AUTO_SEQ |-> $onehot0(st_reg.led_on))
		else $error("more than one output on in sequential mode");
	chk_bright_store: assert property (
		reg_write && reg_addr == `BRIGHT_OFS
		|=> st_reg.bright == {5'h00, $past(reg_wdata[2:0])})
		else $error("brightness code not stored");
endmodule

//--- bench/gate_host.sv
// Host model driving the external gate inputs
`timescale 1ns/1ps
module gate_host (
	input  wire logic       clock,
	input  wire logic [2:0] level,
	input  wire logic       pulse,
	output logic            ext_gate_red,
	output logic            ext_gate_green,
	output logic            ext_gate_blue
);
	logic [2:0] gate_reg = 3'h7; // Unused gates rest high
	always @(posedge clock) begin
		gate_reg <= #1 pulse ? 3'h0 : level; // Low cycle gives edge
	end
	assign {ext_gate_blue, ext_gate_green, ext_gate_red} = gate_reg;
endmodule

//--- bench/rgb_drive_tb.sv
// Self-checking bench for the RGB drive block
`timescale 1ns/1ps
`include "rgb_drive_map.svh"
module rgb_drive_tb;
	import rgb_drive_pkg::*;
	logic        clock = 1'b0;
	logic        reset = 1'b1;
	logic [7:0]  reg_addr = 8'h00;
	logic [7:0]  reg_wdata = 8'h00;
	logic        reg_write = 1'b0;
	logic        reg_read = 1'b0;
	logic [11:0] s_one = 12'h035;
	logic [11:0] s_two = 12'hA9C;
	logic        nvm_write = 1'b0;
	logic [5:0]  nvm_index = 6'h00;
	logic [11:0] nvm_data = 12'h000;
	logic [2:0]  level = 3'h7;
	logic        pulse = 1'b0;
	logic [2:0]  brc_level = 3'h0;
	logic [7:0]  rdata;
	logic        g_r, g_g, g_b, on_r, on_g, on_b;
	logic [7:0]  cur_r, cur_g, cur_b;
	logic [15:0] cnt_r, cnt_g, cnt_b, ovl;
	int          fail_count = 0;
	int          n_tests = 0;

	gate_host host (.clock(clock), .level(level), .pulse(pulse),
		.ext_gate_red(g_r), .ext_gate_green(g_g), .ext_gate_blue(g_b));
	rgb_drive #(.FADE_STEP_CYCLES(4)) dut (.clock(clock), .reset(reset),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
		.reg_read(reg_read), .reg_rdata(rdata), .ext_gate_red(g_r),
		.ext_gate_green(g_g), .ext_gate_blue(g_b), .sensor_input_one(s_one),
		.sensor_input_two(s_two), .pseudo_pwm_level_input(brc_level),
		.nvm_write(nvm_write), .nvm_index(nvm_index), .nvm_data(nvm_data),
		.led_on_red(on_r), .led_on_green(on_g), .led_on_blue(on_b),
		.led_current_red(cur_r), .led_current_green(cur_g),
		.led_current_blue(cur_b));

	initial begin
		forever #12.5 clock = ~clock;
	end

	task automatic final_report();
		$display("Comparisons %0d mismatches %0d", n_tests, fail_count);
		if (fail_count == 0 && n_tests > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	task automatic chk_reg(input logic [7:0] got, input logic [7:0] exp);
		n_tests++;
		if (got !== exp) begin
			fail_count++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic chk_cnt(input logic [15:0] got, input logic [15:0] exp);
		n_tests++;
		if (got !== exp) begin
			fail_count++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clock);
		#1;
		reg_addr = a;
		reg_wdata = d;
		reg_write = 1'b1;
		@(posedge clock);
		#1;
		reg_write = 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		@(posedge clock);
		#1;
		reg_addr = a;
		reg_read = 1'b1;
		@(posedge clock);
		#1;
		reg_read = 1'b0;
		chk_reg(rdata, exp);
	endtask

	task automatic measure(input int n);
		cnt_r = 16'h0000;
		cnt_g = 16'h0000;
		cnt_b = 16'h0000;
		ovl = 16'h0000;
		repeat (n) begin
			@(posedge clock);
			#1;
			if (on_r === 1'b1) cnt_r++;
			if (on_g === 1'b1) cnt_g++;
			if (on_b === 1'b1) cnt_b++;
			if ($countones({on_r, on_g, on_b}) > 1) ovl++;
		end
	endtask

	initial begin
		repeat (100000) @(posedge clock);
		fail_count++;
		final_report();
	end

	initial begin
		repeat (3) @(posedge clock);
		#1;
		reset = 1'b0;
		rd(`CTRL_OFS, 8'h00);
		rd(`BRIGHT_OFS, 8'h07);
		for (int i = 0; i < 3; i++) begin
			rd(`GAIN_R_OFS + 8'(i), 8'h80);
			rd(`CUR_R_OFS + 8'(i), 8'h00);
		end
		wr(`CTRL_OFS, 8'h02);
		wr(`BRIGHT_OFS, 8'hF8);
		rd(`BRIGHT_OFS, 8'h00);
		wr(`GAIN_R_OFS, 8'h00);
		for (int i = 0; i < 3; i++) begin
			wr(`CUR_R_OFS + 8'(i), 8'(8'h35 + 8'h41 * i));
		end
		repeat (2) @(posedge clock);
		#1;
		chk_reg(cur_r, 8'h35);
		chk_reg(cur_b, 8'hB7);
		for (int p = 0; p < 8; p++) begin
			level = 3'(p);
			repeat (3) @(posedge clock);
			#1;
			chk_reg({5'h00, on_b, on_g, on_r}, 8'(p));
		end
		rd(`ADC_LO_OFS, 8'h35);
		rd(`ADC_HI_OFS, 8'h00);
		wr(`CTRL_OFS, 8'h03);
		repeat (2) @(posedge clock);
		rd(`ADC_LO_OFS, 8'h9C);
		rd(`ADC_HI_OFS, 8'h0A);
		for (int i = 0; i < `NVM_WORDS; i++) begin
			@(posedge clock);
			#1;
			nvm_write = 1'b1;
			nvm_index = 6'(i);
			nvm_data = (i < 11) ? 12'(256 * (i + 1)) : (i < 22) ? 12'h200 :
				(i < 33) ? 12'h0F0 : (i < 36) ? 12'(17 * (i - 32)) : 12'h000;
		end
		@(posedge clock);
		#1;
		nvm_write = 1'b0;
		wr(`GAIN_R_OFS, 8'h80);
		wr(`BRIGHT_OFS, 8'h07);
		wr(`CTRL_OFS, 8'h0A);
		repeat (8192) @(posedge clock);
		measure(4096);
		chk_cnt(cnt_r, 16'h0450);
		chk_cnt(cnt_g, 16'h0200);
		chk_cnt(cnt_b, 16'h00F0);
		chk_reg(cur_r, 8'h11);
		chk_reg(cur_g, 8'h22);
		chk_reg(cur_b, 8'h33);
		wr(`GAIN_R_OFS, 8'h40);
		wr(`BRIGHT_OFS, 8'h06);
		repeat (8192) @(posedge clock);
		measure(4096);
		chk_cnt(cnt_r, 16'h0114);
		chk_cnt(cnt_g, 16'h0100);
		chk_cnt(cnt_b, 16'h0078);
		for (int f = 1; f < 4; f++) begin
			wr(`CTRL_OFS, {2'(f), 6'h0A});
			pulse = 1'b1;
			@(posedge clock);
			#1;
			pulse = 1'b0;
			measure(12288);
			chk_cnt(ovl, 16'h0000);
			chk_cnt(16'(cnt_r != 16'h0000), 16'h0001);
			chk_cnt(cnt_g, 16'h0100);
			chk_cnt(cnt_b, (f > 1) ? 16'h0078 : 16'h0000);
		end
		wr(`CTRL_OFS, 8'h00);
		brc_level = 3'h5;
		repeat (4200) @(posedge clock);
		measure(4096);
		chk_cnt(cnt_g, 16'h0080);
		chk_cnt(cnt_b, 16'h003C);
		final_report();
	end
endmodule
